// *** src/ajds_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module ajds_top #(
  parameter logic [ajds_pkg::TMR_W-1:0] INS_DB_CYC = ajds_pkg::TMR_W'(ajds_pkg::INS_DB_CYC),
  parameter logic [ajds_pkg::TMR_W-1:0] REM_DB_CYC = ajds_pkg::TMR_W'(ajds_pkg::REM_DB_CYC),
  parameter logic [ajds_pkg::TMR_W-1:0] DET_CYC    = ajds_pkg::TMR_W'(ajds_pkg::DET_CYC)
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // Jack and comparator pins
  input  wire logic                      jack_sense,
  input  wire logic                      mic_on_sleeve,
  input  wire logic                      mic_on_ring2,
  // Host control bits
  input  wire logic                      manual_en,
  input  wire logic [ajds_pkg::SW_W-1:0] manual_sw,
  input  wire logic                      auto_det_en,
  input  wire logic                      det_cmd,
  input  wire logic                      fm_en,
  input  wire logic [1:0]                db_sel,
  input  wire logic                      key_press_en,
  input  wire logic                      status_read,
  // Switch drive
  output logic [ajds_pkg::SW_W-1:0]      sw_o,
  output logic                           fm_pass_o,
  // Open-drain alert and talker pins
  output logic                           alert_o,
  output logic                           alert_oe,
  output logic                           talker_detected_output_o,
  output logic                           talker_detected_output_oe,
  // Status
  output logic [1:0]                     acc_type_o,
  output logic                           stat_insert_o,
  output logic                           stat_remove_o,
  output logic                           key_det_en_o,
  output logic                           sleep_o
);
  import ajds_pkg::*;

  typedef struct packed {
    logic             sense_m;
    logic             sense_s;
    logic             mic_s_m;
    logic             mic_s_s;
    logic             mic_r_m;
    logic             mic_r_s;
    ajds_state_t      st;
    logic             det_arm;
    logic [1:0]       typ;
    logic [SW_W-1:0]  sw;
    logic             alert_o;
    logic             alert_oe;
    logic             talker_o;
    logic             talker_oe;
    logic             fm_pass;
    logic             sleep;
    logic             st_ins;
    logic             st_rem;
    logic             key_en;
    logic             tmr_start;
    logic [TMR_W-1:0] tmr_load;
  } ajds_top_t;

  // Jack open reads high, so sense synchronisers reset high
  localparam ajds_top_t Q_RST = '{
    st:      S_IDLE,
    sw:      SW_NOINS,
    sense_m: 1'b1,
    sense_s: 1'b1,
    sleep:   1'b1,
    default: '0
  };

  ajds_top_t  q;
  ajds_top_t  d;
  logic [1:0] rst_q;
  logic       rst_n;
  logic       expire_ok;
  logic       ev_ins;
  logic       ev_rem;
  logic       blocked;

  ajds_tmr_if tm ();

  ajds_timer u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .tm    (tm)
  );

  // Reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Timer pulse is stale while a reload is still in flight
  assign expire_ok = tm.expire && !q.tmr_start;
  assign tm.start  = q.tmr_start;
  assign tm.load   = q.tmr_load;

  function automatic logic [TMR_W-1:0] ins_len(input logic [1:0] sel);
    case (sel)
      DB_SEL_HALF: ins_len = INS_DB_CYC >> 1;
      DB_SEL_QRT:  ins_len = INS_DB_CYC >> 2;
      DB_SEL_DBL:  ins_len = INS_DB_CYC << 1;
      default:     ins_len = INS_DB_CYC;
    endcase
  endfunction

  function automatic logic [SW_W-1:0] route(input logic [1:0] typ);
    case (typ)
      TYP_3POLE: route = SW_3POLE;
      TYP_4STD:  route = SW_4STD;
      TYP_4OMTP: route = SW_4OMTP;
      default:   route = SW_NOINS;
    endcase
  endfunction

  always_comb begin
    d = q;
    ev_ins = 1'b0;
    ev_rem = 1'b0;
    d.sense_m = jack_sense;
    d.sense_s = q.sense_m;
    d.mic_s_m = mic_on_sleeve;
    d.mic_s_s = q.mic_s_m;
    d.mic_r_m = mic_on_ring2;
    d.mic_r_s = q.mic_r_m;
    d.alert_o = 1'b0;
    d.talker_o = 1'b0;
    d.tmr_start = 1'b0;
    if (det_cmd) begin
      d.det_arm = 1'b1;
    end
    case (q.st)
      S_IDLE: begin
        if (!q.sense_s) begin
          d.st = S_INSDB;
          d.tmr_start = 1'b1;
          d.tmr_load = ins_len(db_sel);
        end
      end
      S_INSDB: begin
        if (q.sense_s) begin
          // Timer stopped; next steady low starts from zero
          d.st = S_IDLE;
          d.tmr_start = 1'b1;
          d.tmr_load = '0;
        end else if (expire_ok) begin
          if (auto_det_en || d.det_arm) begin
            d.st = S_DET;
            d.det_arm = 1'b0;
            d.tmr_start = 1'b1;
            d.tmr_load = DET_CYC;
          end else begin
            d.st = S_INS;
            d.typ = TYP_NONE;
          end
        end
      end
      S_DET: begin
        if (q.sense_s) begin
          ev_rem = 1'b1;
        end else if (expire_ok) begin
          d.st = S_APPLY;
          if (q.mic_s_s) begin
            d.typ = TYP_4STD;
          end else if (q.mic_r_s) begin
            d.typ = TYP_4OMTP;
          end else begin
            d.typ = TYP_3POLE;
          end
        end
      end
      S_APPLY: begin
        // Switches took the route last edge unless manual_en holds them, alert follows now
        if (q.sense_s) begin
          ev_rem = 1'b1;
        end else begin
          d.st = S_INS;
          ev_ins = 1'b1;
          d.talker_oe = (q.typ == TYP_4STD) || (q.typ == TYP_4OMTP);
        end
      end
      S_INS: begin
        if (q.sense_s) begin
          ev_rem = 1'b1;
        end else if (det_cmd) begin
          d.st = S_DET;
          d.det_arm = 1'b0;
          d.typ = TYP_NONE;
          d.tmr_start = 1'b1;
          d.tmr_load = DET_CYC;
        end
      end
      S_REM: begin
        if (expire_ok) begin
          d.st = S_IDLE;
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    if (ev_rem) begin
      d.st = S_REM;
      d.typ = TYP_NONE;
      d.talker_oe = 1'b0;
      d.tmr_start = 1'b1;
      d.tmr_load = REM_DB_CYC;
    end
    // Clear by the status read, but a new event wins
    if (status_read) begin
      d.alert_oe = 1'b0;
      d.st_ins = 1'b0;
      d.st_rem = 1'b0;
    end
    if (ev_ins) begin
      d.alert_oe = 1'b1;
      d.st_ins = 1'b1;
    end
    if (ev_rem) begin
      d.alert_oe = 1'b1;
      d.st_rem = 1'b1;
    end
    // Manual writes are parked while debounce or detection runs
    blocked = (d.st == S_INSDB) || (d.st == S_DET) || (d.st == S_REM);
    if (manual_en) begin
      if (!blocked) begin
        d.sw = manual_sw;
      end
    end else begin
      d.sw = route(d.typ);
    end
    d.fm_pass = fm_en && (d.sw[SW_GND_SLV] || d.sw[SW_GND_R2]);
    d.sleep = (d.st == S_IDLE) && !manual_en;
    // Key detection only honoured with a four-pole headset seated
    d.key_en = key_press_en && (d.st == S_INS) && d.talker_oe;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= Q_RST;
    end else begin
      q <= d;
    end
  end

  assign sw_o                      = q.sw;
  assign fm_pass_o                 = q.fm_pass;
  assign alert_o                   = q.alert_o;
  assign alert_oe                  = q.alert_oe;
  assign talker_detected_output_o  = q.talker_o;
  assign talker_detected_output_oe = q.talker_oe;
  assign acc_type_o                = q.typ;
  assign stat_insert_o             = q.st_ins;
  assign stat_remove_o             = q.st_rem;
  assign key_det_en_o              = q.key_en;
  assign sleep_o                   = q.sleep;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_db_start_low;
    (q.st == S_INSDB && $past(q.st) == S_IDLE) |-> !$past(q.sense_s);
  endproperty
  a_db_start_low: assert property (p_db_start_low) else $error("debounce began without low sense");

  property p_db_restart;
    (q.st == S_INSDB && q.sense_s) |=> (q.st == S_IDLE && q.tmr_start && q.tmr_load == '0);
  endproperty
  a_db_restart: assert property (p_db_restart) else $error("high sense did not abort debounce");

  property p_det_start;
    (q.st == S_INSDB && expire_ok && !q.sense_s && auto_det_en) |=> (q.st == S_DET && q.tmr_load == DET_CYC);
  endproperty
  a_det_start: assert property (p_det_start) else $error("detection did not follow debounce");

  property p_route_then_alert;
    (q.st == S_APPLY && !q.sense_s && !manual_en)
      |-> (q.sw == route(q.typ)) ##1 (q.alert_oe && q.talker_oe == (q.typ != TYP_3POLE));
  endproperty
  a_route_then_alert: assert property (p_route_then_alert) else $error("alert before routing");

  property p_alert_release;
    $fell(q.alert_oe) |-> $past(status_read);
  endproperty
  a_alert_release: assert property (p_alert_release) else $error("alert dropped without status read");

  property p_removal;
    (q.st == S_INS && q.sense_s && !manual_en)
      |=> (q.st == S_REM && q.alert_oe && !q.talker_oe && q.sw == SW_NOINS);
  endproperty
  a_removal: assert property (p_removal) else $error("removal handling wrong");

  property p_rem_end;
    (q.st == S_REM && expire_ok) |=> (q.st == S_IDLE && q.sleep == !$past(manual_en));
  endproperty
  a_rem_end: assert property (p_rem_end) else $error("removal debounce did not end to idle");

  property p_abort_det;
    (q.st == S_DET && q.sense_s) |=> (q.st == S_REM && q.tmr_load == REM_DB_CYC);
  endproperty
  a_abort_det: assert property (p_abort_det) else $error("removal did not abort detection");

  property p_manual_hold;
    (q.st == S_INS && q.sense_s && manual_en) |=> $stable(q.sw);
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("switches moved under manual control");

  property p_no_bias;
    (q.st == S_IDLE && !manual_en) |=> !q.sw[SW_BIAS];
  endproperty
  a_no_bias: assert property (p_no_bias) else $error("bias connected with no insertion");

  property p_fm;
    q.fm_pass |-> $past(fm_en);
  endproperty
  a_fm: assert property (p_fm) else $error("FM pass without enable");

  property p_sleep;
    q.sleep |-> (q.st == S_IDLE);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outside idle");
endmodule // ajds_top
`default_nettype wire

// *** include/ajds_pkg.sv ***
package ajds_pkg;
  // Timebase
  localparam int CLK_MHZ    = 125;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  // Sequencer times in ms
  localparam int INS_DB_MS = 90;
  localparam int REM_DB_MS = 50;
  localparam int DET_MS    = 80;
  localparam int INS_DB_CYC = INS_DB_MS * CYC_PER_MS;
  localparam int REM_DB_CYC = REM_DB_MS * CYC_PER_MS;
  localparam int DET_CYC    = DET_MS * CYC_PER_MS;
  localparam int TMR_W      = 26;
  // Insertion debounce scaling selections
  localparam logic [1:0] DB_SEL_NOM  = 2'h0;
  localparam logic [1:0] DB_SEL_HALF = 2'h1;
  localparam logic [1:0] DB_SEL_QRT  = 2'h2;
  localparam logic [1:0] DB_SEL_DBL  = 2'h3;
  // Switch vector bit positions
  localparam int SW_W       = 7;
  localparam int SW_MIC_SLV = 0;
  localparam int SW_MIC_R2  = 1;
  localparam int SW_GND_SLV = 2;
  localparam int SW_GND_R2  = 3;
  localparam int SW_DEP_SLV = 4;
  localparam int SW_DEP_R2  = 5;
  localparam int SW_BIAS    = 6;
  // Switch patterns per accessory
  localparam logic [SW_W-1:0] SW_NOINS = 7'h30;
  localparam logic [SW_W-1:0] SW_3POLE = 7'h0C;
  localparam logic [SW_W-1:0] SW_4STD  = 7'h49;
  localparam logic [SW_W-1:0] SW_4OMTP = 7'h46;
  // Accessory type codes
  localparam logic [1:0] TYP_NONE  = 2'h0;
  localparam logic [1:0] TYP_3POLE = 2'h1;
  localparam logic [1:0] TYP_4STD  = 2'h2;
  localparam logic [1:0] TYP_4OMTP = 2'h3;
  typedef enum logic [2:0] {
    S_IDLE,
    S_INSDB,
    S_DET,
    S_APPLY,
    S_INS,
    S_REM
  } ajds_state_t;
endpackage

// *** include/ajds_tmr_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface ajds_tmr_if;
  logic                      start;
  logic [ajds_pkg::TMR_W-1:0] load;
  logic                      expire;
  modport ctl (output start, output load, input expire);
  modport tmr (input start, input load, output expire);
endinterface
`default_nettype wire

// *** src/ajds_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module ajds_timer (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Control
  ajds_tmr_if.tmr     tm
);
  import ajds_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             expire;
  } ajds_tmr_t;

  ajds_tmr_t q;
  ajds_tmr_t d;

  // Load of zero stops the count
  always_comb begin
    d = q;
    d.expire = 1'b0;
    if (tm.start) begin
      d.cnt = tm.load;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - TMR_W'(1);
      d.expire = (q.cnt == TMR_W'(1));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tm.expire = q.expire;
endmodule // ajds_timer
`default_nettype wire

// *** test/ajds_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module ajds_host (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // From the sequencer
  input  wire logic       alert_oe,
  input  wire logic [1:0] acc_type_o,
  // Host control bits
  output logic            status_read,
  output logic            key_press_en,
  output logic            fm_en
);
  logic [4:0] cnt_q;
  logic       slow_q;
  // Alternating quick and slow reads, so both latencies are seen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_read  <= 1'b0;
      key_press_en <= 1'b0;
      fm_en        <= 1'b0;
      cnt_q        <= 5'h00;
      slow_q       <= 1'b0;
    end else begin
      status_read  <= 1'b0;
      fm_en        <= slow_q;
      key_press_en <= acc_type_o[1];
      if (alert_oe && !status_read) begin
        if (cnt_q == (slow_q ? 5'h19 : 5'h02)) begin
          status_read <= 1'b1;
          cnt_q       <= 5'h00;
          slow_q      <= !slow_q;
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end else begin
        cnt_q <= 5'h00;
      end
    end
  end
endmodule // ajds_host
`default_nettype wire

// *** test/ajds_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module ajds_top_tb;
  import ajds_pkg::*;
  localparam int INS = 40;
  localparam int REM = 30;
  localparam int DET = 20;
  typedef struct packed {
    logic [1:0]      acc;
    logic [SW_W-1:0] sw;
    logic            tk;
    logic            ins;
    logic            rem;
  } ajds_note_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic jack_sense = 1'b1;
  logic mic_on_sleeve = 1'b0;
  logic mic_on_ring2 = 1'b0;
  logic manual_en = 1'b0;
  logic [SW_W-1:0] manual_sw = 7'h00;
  logic auto_det_en = 1'b1;
  logic det_cmd = 1'b0;
  logic fm_en, key_press_en, status_read;
  logic [SW_W-1:0] sw_o;
  logic fm_pass_o, alert_oe, tk_oe, stat_insert_o, stat_remove_o, key_det_en_o, sleep_o;
  logic alert_o, tk_o;
  logic [1:0] db_sel = DB_SEL_NOM;
  logic [1:0] acc_type_o;
  logic prev_q = 1'b0;
  logic [31:0] rnd = 32'h8856;
  ajds_note_t q[$];
  int n_errors = 0;
  int checks = 0;
  always #4 clk = ~clk;
  ajds_top #(.INS_DB_CYC(26'(INS)), .REM_DB_CYC(26'(REM)), .DET_CYC(26'(DET))) ajds_top_inst (
    .clk(clk), .rstn(rstn), .jack_sense(jack_sense), .mic_on_sleeve(mic_on_sleeve),
    .mic_on_ring2(mic_on_ring2), .manual_en(manual_en), .manual_sw(manual_sw),
    .auto_det_en(auto_det_en), .det_cmd(det_cmd), .fm_en(fm_en), .db_sel(db_sel),
    .key_press_en(key_press_en), .status_read(status_read), .sw_o(sw_o), .fm_pass_o(fm_pass_o),
    .alert_o(alert_o), .alert_oe(alert_oe), .talker_detected_output_o(tk_o), .talker_detected_output_oe(tk_oe),
    .acc_type_o(acc_type_o), .stat_insert_o(stat_insert_o), .stat_remove_o(stat_remove_o),
    .key_det_en_o(key_det_en_o), .sleep_o(sleep_o));
  ajds_host ajds_host_inst (.clk(clk), .rstn(rstn), .alert_oe(alert_oe), .acc_type_o(acc_type_o),
    .status_read(status_read), .key_press_en(key_press_en), .fm_en(fm_en));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk_evt(input ajds_note_t got, input ajds_note_t exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t event got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_lvl(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  task automatic wait_alert(input logic v, output int c);
    c = 0;
    while (alert_oe !== v && c < 1000) begin
      @(posedge clk);
      #1;
      c++;
    end
    if (c >= 1000) begin
      n_errors++;
      $display("CHECK FAILED t=%0t alert wait timed out", $time);
    end
  endtask
  task automatic test_done;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One insertion and removal; options for glitch, manual, early removal, host command
  task automatic run(input logic [1:0] ty, input bit man, input bit early, input bit glitch, input bit cmd);
    int c;
    int il;
    logic [SW_W-1:0] sw;
    rnd = lfsr(rnd);
    il = cmd ? INS / 4 : INS;
    sw = man ? rnd[6:0] : (ty == TYP_3POLE ? SW_3POLE : (ty == TYP_4STD ? SW_4STD : SW_4OMTP));
    @(posedge clk);
    mic_on_sleeve <= (ty == TYP_4STD);
    mic_on_ring2  <= (ty == TYP_4OMTP);
    manual_en     <= man;
    manual_sw     <= rnd[6:0];
    auto_det_en   <= !cmd;
    db_sel        <= cmd ? DB_SEL_QRT : DB_SEL_NOM;
    if (glitch) begin
      jack_sense <= 1'b0;
      repeat (10 + int'(rnd[12:8] % 20)) @(posedge clk);
      jack_sense <= 1'b1;
      repeat (4) @(posedge clk);
    end
    jack_sense <= 1'b0;
    if (!early) begin
      q.push_back(ajds_note_t'{ty, sw, ty[1], 1'b1, 1'b0});
      if (cmd) begin
        repeat (5) @(posedge clk);
        det_cmd <= 1'b1;
        @(posedge clk);
        det_cmd <= 1'b0;
      end
      wait_alert(1'b1, c);
      chk_lvl(c >= il + DET - 6 && c <= il + DET + 12, 1'b1, "insertion timing");
      chk_lvl(alert_o || tk_o, 1'b0, "open-drain pins not pulled low");
      wait_alert(1'b0, c);
      chk_lvl(c <= 30, 1'b1, "alert not released after read");
      repeat (3) @(posedge clk);
      #1;
      chk_lvl(key_det_en_o, ty[1], "key detection enable");
      chk_lvl(fm_pass_o, fm_en && (sw[SW_GND_SLV] || sw[SW_GND_R2]), "fm pass");
      @(posedge clk);
      // Host command while seated runs detection again
      if (cmd) begin
        q.push_back(ajds_note_t'{ty, sw, ty[1], 1'b1, 1'b0});
        det_cmd <= 1'b1;
        @(posedge clk);
        det_cmd <= 1'b0;
        wait_alert(1'b1, c);
        chk_lvl(c >= DET && c <= DET + 12, 1'b1, "re-detection timing");
        wait_alert(1'b0, c);
        chk_lvl(c <= 30, 1'b1, "alert not released after re-detection read");
        @(posedge clk);
      end
    end else begin
      repeat (INS + 10) @(posedge clk);
    end
    // Manual control holds the switches through removal
    q.push_back(ajds_note_t'{TYP_NONE, man ? sw : SW_NOINS, 1'b0, 1'b0, 1'b1});
    jack_sense <= 1'b1;
    wait_alert(1'b1, c);
    chk_lvl(c <= 6, 1'b1, "removal not immediate");
    repeat (REM - 10) @(posedge clk);
    #1;
    chk_lvl(sleep_o, 1'b0, "sleep before removal debounce");
    repeat (20) @(posedge clk);
    #1;
    chk_lvl(sleep_o, !man, "sleep after removal debounce");
    @(posedge clk);
  endtask
  // Result watcher: each alert rise takes the oldest note; falling edge sees settled outputs
  always @(negedge clk) begin
    prev_q <= alert_oe;
    if (alert_oe === 1'b1 && prev_q === 1'b0) begin
      if (q.size() == 0) begin
        n_errors++;
        $display("CHECK FAILED t=%0t unexpected alert", $time);
      end else begin
        chk_evt({acc_type_o, sw_o, tk_oe, stat_insert_o, stat_remove_o}, q.pop_front());
      end
    end
  end
  initial begin
    repeat (10000) @(posedge clk);
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    test_done;
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_lvl(sw_o[SW_BIAS], 1'b0, "bias connected at rest");
    chk_lvl(sleep_o, 1'b1, "not asleep at rest");
    run(TYP_3POLE, 1'b0, 1'b0, 1'b0, 1'b0);
    run(TYP_4STD, 1'b0, 1'b0, 1'b1, 1'b0);
    run(TYP_4OMTP, 1'b0, 1'b0, 1'b0, 1'b0);
    run(TYP_4STD, 1'b1, 1'b0, 1'b0, 1'b0);
    run(TYP_4STD, 1'b0, 1'b1, 1'b0, 1'b0);
    run(TYP_3POLE, 1'b0, 1'b0, 1'b0, 1'b1);
    chk_lvl(q.size() == 0, 1'b1, "missing alert");
    test_done;
  end
endmodule // ajds_top_tb
`default_nettype wire
